// *** rtl/scp_panel.sv ***
// Front-panel set-up controller: maximum response time setting and
// analog output minimum / full-scale calibration.
// Pins arrive asynchronously; op_mode, range period and run LEDs are
// on the panel clock. Stored values model the non-volatile memory.
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
// Notes on behaviour
// - In max-response section, green flashes stored setting count, pauses, repeats.
// - Setting 0 gives 1024 input periods, clamped to 40 ms .. 10 s.
// - Settings 1..9 give 10 ms up to 10 s fixed times, also cut-out.
// - First press in that section opens editing; green flashes fast.
// - Next press latches rotary as setting, then count-flashes it.
// - Invalid rotary value is rejected; red flashes until a valid entry.
// - Factory calibration for every mode is held and applied per mode.
// - User calibration covers one mode; other mode reverts to factory.
// - Values may not exceed factory full scale plus 10 percent.
// - Each step press adds to the pending adjustment before saving.
// - Rotary 1..8 select step sizes 3 mV/5 uA up to 400 mV/800 uA.
// - Direction starts increasing on every calibration entry.
// - Press at 9 toggles direction; red off for up, on for down.
// - Calibration entry flashes green slowly; press enables rotary, faster flash.
// - Each armed press at 1..8 moves the live value by the step and direction.
// - Press at 0 saves adjusted value as user calibration.
// - After re-entry, an arming press then two armed presses at 0 reload factory calibration.
// - Minimum going below absolute minimum clamps there, red flashes.
// - Full scale going above factory full scale plus 10 percent clamps there, red flashes.
// - Crossing full scale and minimum sets both equal, red flashes.
// - Config switch down ends set-up and returns to running.
module scp_panel #(
  parameter int TICK_CYCLES = (`SCP_CLK_HZ / 1000000) * `SCP_TICK_US
) (
  input  wire logic        clock,           // 40 MHz panel clock
  input  wire logic        rst,             // async reset, active high
  input  wire logic        cfg_en_pin,      // switch 4, high = set-up
  input  wire logic [2:0]  sel_pin,         // {sw7, sw6, sw5}
  input  wire logic [3:0]  rotary_pin,      // rotary switch position
  input  wire logic        button_pin,      // push-button, high = pressed
  input  wire logic [2:0]  op_mode,         // selected operating mode 1..4
  input  wire logic [23:0] range_period_us, // input range period
  input  wire logic        run_led_green,   // green in normal running
  input  wire logic        run_led_red,     // red in normal running
  output logic             led_green,       // input LED
  output logic             led_red,         // output LED
  output logic [3:0]       max_resp_setting,// stored setting 0..9
  output logic [23:0]      max_resp_us,     // max response / cut-out time
  output logic [15:0]      cal_min,         // live minimum output code
  output logic [15:0]      cal_fs,          // live full-scale output code
  output logic             user_cal_valid,  // user calibration in force
  output logic             nvm_save         // pulse: calibration stored or factory reloaded
);
  import scp_pkg::*;

  scp_ui_if ui ();

  // Pin synchronisers: first stage feeds only the second
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta <= 9'h000;
      pin_sync <= 9'h000;
    end else begin
      pin_meta <= {cfg_en_pin, sel_pin, rotary_pin, button_pin};
      pin_sync <= pin_meta;
    end
  end
  wire       cfg_en = pin_sync[8];
  wire [2:0] sel    = pin_sync[7:5];
  wire [3:0] rot    = pin_sync[4:1];

  // 1 ms tick divider
  logic [15:0] div_cnt;
  wire div_end = (div_cnt == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_end ? 16'h0000 : div_cnt + 16'h0001;
    end
  end
  assign ui.tick = div_end;

  scp_debounce u_deb (
    .clock  (clock),
    .rst    (rst),
    .button (pin_sync[0]),
    .ui     (ui)
  );

  scp_blinker u_blk (
    .clock (clock),
    .rst   (rst),
    .ui    (ui)
  );

  function automatic logic is_current(input logic [2:0] m);
    return (m == `SCP_MODE_I20) || (m == `SCP_MODE_I420);
  endfunction

  function automatic logic [15:0] fac_min(input logic [2:0] m);
    if (m == `SCP_MODE_I420) return `SCP_FAC_MIN_I420;
    return is_current(m) ? `SCP_FAC_MIN_I20 : `SCP_FAC_MIN_V;
  endfunction

  function automatic logic [15:0] fac_fs(input logic [2:0] m);
    if (is_current(m)) return `SCP_FAC_FS_I;
    return (m == `SCP_MODE_V5) ? `SCP_FAC_FS_V5 : `SCP_FAC_FS_V10;
  endfunction

  function automatic logic [15:0] step_size(input logic [2:0] m, input logic [3:0] p);
    logic c;
    c = is_current(m);
    unique case (p)
      4'h1:    return c ? `SCP_STEP_I1 : `SCP_STEP_V1;
      4'h2:    return c ? `SCP_STEP_I2 : `SCP_STEP_V2;
      4'h3:    return c ? `SCP_STEP_I3 : `SCP_STEP_V3;
      4'h4:    return c ? `SCP_STEP_I4 : `SCP_STEP_V4;
      4'h5:    return c ? `SCP_STEP_I5 : `SCP_STEP_V5;
      4'h6:    return c ? `SCP_STEP_I6 : `SCP_STEP_V6;
      4'h7:    return c ? `SCP_STEP_I7 : `SCP_STEP_V7;
      4'h8:    return c ? `SCP_STEP_I8 : `SCP_STEP_V8;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [23:0] mr_time_us(input logic [3:0] s, input logic [23:0] per);
    logic [33:0] span;
    span = {per, 10'h000};
    unique case (s)
      4'h0: begin
        if (span < `SCP_MR_MIN_US) return 24'(`SCP_MR_MIN_US);
        if (span > `SCP_MR_MAX_US) return 24'(`SCP_MR_MAX_US);
        return span[23:0];
      end
      4'h1:    return `SCP_MR_T1_US;
      4'h2:    return `SCP_MR_T2_US;
      4'h3:    return `SCP_MR_T3_US;
      4'h4:    return `SCP_MR_T4_US;
      4'h5:    return `SCP_MR_T5_US;
      4'h6:    return `SCP_MR_T6_US;
      4'h7:    return `SCP_MR_T7_US;
      4'h8:    return `SCP_MR_T8_US;
      default: return `SCP_MR_T9_US;
    endcase
  endfunction

  // Section decode; anything else in set-up is handled elsewhere
  wire in_mr   = cfg_en && (sel == `SCP_SEL_MAXRESP);
  wire in_min  = cfg_en && (sel == `SCP_SEL_CAL_MIN);
  wire in_fs   = cfg_en && (sel == `SCP_SEL_CAL_FS);
  wire [2:0] sect = {in_fs, in_min, in_mr};

  scp_state_t state;
  scp_state_t next_state;
  logic [2:0] sect_q;
  logic       dir_down;
  logic       cal_err;
  logic       adjusted;
  logic [1:0] zero_cnt;
  logic       cal_is_min;
  logic [2:0] user_mode;
  logic [15:0] user_min;
  logic [15:0] user_fs;

  wire press     = ui.press;
  wire entering  = (sect != sect_q);
  wire rot_valid = (rot <= `SCP_MR_VALID_MAX);
  wire rot_step  = (rot != `SCP_ROT_SAVE) && (rot != `SCP_ROT_DIR) && rot_valid;
  wire stored_ok = user_cal_valid && (user_mode == op_mode);

  // Adjustment arithmetic with clamping
  wire [15:0] step    = step_size(op_mode, rot);
  wire [15:0] fsf     = fac_fs(op_mode);
  wire [16:0] fs_marg = {1'b0, fsf} + {1'b0, fsf / `SCP_FS_MARGIN_DIV};
  wire [15:0] abs_max = is_current(op_mode) ? `SCP_ABS_MAX_I : `SCP_ABS_MAX_V;
  wire [15:0] lim     = (fs_marg > {1'b0, abs_max}) ? abs_max : fs_marg[15:0];
  wire [16:0] min_up  = {1'b0, cal_min} + {1'b0, step};
  wire [16:0] fs_up   = {1'b0, cal_fs} + {1'b0, step};
  wire        min_low = (cal_min < step + `SCP_ABS_MIN);
  wire        fs_low  = (cal_fs < step) || (cal_fs - step < cal_min);
  wire        min_hi  = (min_up > {1'b0, cal_fs}) || (min_up > {1'b0, lim});

  logic [15:0] next_min;
  logic [15:0] next_fs;
  logic        next_err;
  always_comb begin
    next_min = cal_min;
    next_fs  = cal_fs;
    next_err = 1'b0;
    if (cal_is_min && dir_down) begin
      next_min = min_low ? `SCP_ABS_MIN : cal_min - step;
      next_err = min_low;
    end else if (cal_is_min) begin
      next_min = min_hi ? ((cal_fs < lim) ? cal_fs : lim) : min_up[15:0];
      next_err = min_hi;
    end else if (dir_down) begin
      next_fs  = fs_low ? cal_min : cal_fs - step;
      next_err = fs_low;
    end else begin
      next_fs  = (fs_up > {1'b0, lim}) ? lim : fs_up[15:0];
      next_err = (fs_up > {1'b0, lim});
    end
  end

  always_comb begin
    next_state = state;
    if (!cfg_en) begin
      next_state = SCP_ST_RUN;
    end else if (entering || state == SCP_ST_RUN) begin
      next_state = in_mr ? SCP_ST_MR_SHOW
                 : (in_min || in_fs) ? SCP_ST_CAL_SLOW : SCP_ST_OTHER;
    end else if (press) begin
      unique case (state)
        SCP_ST_MR_SHOW:  next_state = SCP_ST_MR_EDIT;
        SCP_ST_MR_EDIT,
        SCP_ST_MR_BAD:   next_state = rot_valid ? SCP_ST_MR_SHOW : SCP_ST_MR_BAD;
        SCP_ST_CAL_SLOW: next_state = SCP_ST_CAL_ARM;
        default:         next_state = state;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state            <= SCP_ST_RUN;
      sect_q           <= 3'h0;
      max_resp_setting <= `SCP_MR_RESET;
    end else begin
      state  <= next_state;
      sect_q <= sect;
      if (press && rot_valid && (state == SCP_ST_MR_EDIT || state == SCP_ST_MR_BAD)) begin
        max_resp_setting <= rot;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      max_resp_us <= `SCP_MR_T1_US;
    end else begin
      max_resp_us <= mr_time_us(max_resp_setting, range_period_us);
    end
  end

  // Calibration routine bookkeeping
  wire armed_press = press && !entering && (state == SCP_ST_CAL_ARM);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_down   <= 1'b0;
      cal_err    <= 1'b0;
      adjusted   <= 1'b0;
      zero_cnt   <= 2'h0;
      cal_is_min <= 1'b0;
    end else if (entering) begin
      dir_down   <= 1'b0;
      cal_err    <= 1'b0;
      adjusted   <= 1'b0;
      zero_cnt   <= 2'h0;
      cal_is_min <= in_min;
    end else if (armed_press) begin
      cal_err <= rot_step ? next_err : 1'b0;
      if (rot == `SCP_ROT_DIR) begin
        dir_down <= !dir_down;
      end
      if (rot_step) begin
        adjusted <= 1'b1;
        zero_cnt <= 2'h0;
      end else if (rot == `SCP_ROT_SAVE) begin
        adjusted <= 1'b0;
        zero_cnt <= (adjusted || zero_cnt == 2'h2) ? 2'h0 : zero_cnt + 2'h1;
      end
    end
  end

  // Live values follow storage outside the routines
  wire save_now    = armed_press && (rot == `SCP_ROT_SAVE) && adjusted;
  wire restore_now = armed_press && (rot == `SCP_ROT_SAVE) && !adjusted
                     && (zero_cnt == 2'h1);
  wire calibrating = (state == SCP_ST_CAL_SLOW) || (state == SCP_ST_CAL_ARM);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cal_min <= `SCP_FAC_MIN_V;
      cal_fs  <= `SCP_FAC_FS_V10;
    end else if (!calibrating || restore_now || entering) begin
      cal_min <= stored_ok && !restore_now ? user_min : fac_min(op_mode);
      cal_fs  <= stored_ok && !restore_now ? user_fs : fac_fs(op_mode);
    end else if (armed_press && rot_step) begin
      cal_min <= next_min;
      cal_fs  <= next_fs;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      user_cal_valid <= 1'b0;
      user_mode      <= `SCP_MODE_V10;
      user_min       <= 16'h0000;
      user_fs        <= 16'h0000;
      nvm_save       <= 1'b0;
    end else begin
      nvm_save <= save_now || restore_now;
      if (save_now) begin
        user_cal_valid <= 1'b1;
        user_mode      <= op_mode;
        user_min       <= cal_min;
        user_fs        <= cal_fs;
      end else if (restore_now || (user_mode != op_mode)) begin
        user_cal_valid <= 1'b0;
      end
    end
  end

  // LED selection
  assign ui.blink_count = max_resp_setting;
  assign ui.blink_mode  = (state == SCP_ST_MR_SHOW)  ? SCP_BLINK_COUNT
                        : (state == SCP_ST_MR_EDIT ||
                           state == SCP_ST_CAL_ARM)  ? SCP_BLINK_FAST
                        : (state == SCP_ST_CAL_SLOW) ? SCP_BLINK_SLOW : SCP_BLINK_OFF;
  wire red_cal = cal_err ? ui.fast_phase : dir_down;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      led_green <= 1'b0;
      led_red   <= 1'b0;
    end else begin
      led_green <= (state == SCP_ST_RUN) ? run_led_green : ui.blink_led;
      led_red   <= (state == SCP_ST_RUN)    ? run_led_red
                 : (state == SCP_ST_MR_BAD) ? ui.fast_phase
                 : (state == SCP_ST_CAL_ARM || state == SCP_ST_CAL_SLOW) ? red_cal
                 : 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** common/scp_cfg.svh ***
// Set-up panel constants: section codes, timing in ms ticks, response times,
// calibration steps, factory values and output limits.
// Assumes a single 40 MHz clock; included by bare name.
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

`define SCP_CLK_HZ        40000000
`define SCP_TICK_US       1000
`define SCP_DEBOUNCE_MS   8'd20
`define SCP_FAST_HALF_MS  12'd100
`define SCP_SLOW_HALF_MS  12'd500
`define SCP_CNT_ON_MS     12'd250
`define SCP_CNT_OFF_MS    12'd250
`define SCP_CNT_PAUSE_MS  12'd1500

// Selector code {sw7, sw6, sw5}
`define SCP_SEL_MAXRESP   3'h3
`define SCP_SEL_CAL_MIN   3'h5
`define SCP_SEL_CAL_FS    3'h7

`define SCP_ROT_SAVE      4'h0
`define SCP_ROT_DIR       4'h9
`define SCP_MR_RESET      4'h0
`define SCP_MR_VALID_MAX  4'h9

`define SCP_MR_SHIFT      10
`define SCP_MR_MIN_US     34'h0000009c40
`define SCP_MR_MAX_US     34'h0000989680
`define SCP_MR_T1_US      24'h002710
`define SCP_MR_T2_US      24'h004e20
`define SCP_MR_T3_US      24'h00c350
`define SCP_MR_T4_US      24'h0186a0
`define SCP_MR_T5_US      24'h030d40
`define SCP_MR_T6_US      24'h07a120
`define SCP_MR_T7_US      24'h0f4240
`define SCP_MR_T8_US      24'h4c4b40
`define SCP_MR_T9_US      24'h989680

// Operating modes: 1=0-5V 2=0-10V 3=0-20mA 4=4-20mA
`define SCP_MODE_V5       3'h1
`define SCP_MODE_V10      3'h2
`define SCP_MODE_I20      3'h3
`define SCP_MODE_I420     3'h4

// Output codes: 1 mV or 1 uA per code
`define SCP_ABS_MIN       16'h0000
`define SCP_ABS_MAX_V     16'h2ee0
`define SCP_ABS_MAX_I     16'h5dc0
`define SCP_FS_MARGIN_DIV 16'h000a
`define SCP_FAC_MIN_V     16'h0000
`define SCP_FAC_MIN_I20   16'h0000
`define SCP_FAC_MIN_I420  16'h0fa0
`define SCP_FAC_FS_V5     16'h1388
`define SCP_FAC_FS_V10    16'h2710
`define SCP_FAC_FS_I      16'h4e20

`define SCP_STEP_V1 16'h0003
`define SCP_STEP_V2 16'h0005
`define SCP_STEP_V3 16'h000a
`define SCP_STEP_V4 16'h0019
`define SCP_STEP_V5 16'h0032
`define SCP_STEP_V6 16'h0064
`define SCP_STEP_V7 16'h00c8
`define SCP_STEP_V8 16'h0190
`define SCP_STEP_I1 16'h0005
`define SCP_STEP_I2 16'h000a
`define SCP_STEP_I3 16'h0019
`define SCP_STEP_I4 16'h0032
`define SCP_STEP_I5 16'h0064
`define SCP_STEP_I6 16'h00c8
`define SCP_STEP_I7 16'h0190
`define SCP_STEP_I8 16'h0320

`endif

// *** common/scp_pkg.sv ***
// Types shared by the set-up panel modules.
// Constants live in scp_cfg.svh.
package scp_pkg;
  typedef enum logic [1:0] {
    SCP_BLINK_OFF,
    SCP_BLINK_SLOW,
    SCP_BLINK_FAST,
    SCP_BLINK_COUNT
  } scp_blink_t;

  typedef enum logic [2:0] {
    SCP_ST_RUN,
    SCP_ST_OTHER,
    SCP_ST_MR_SHOW,
    SCP_ST_MR_EDIT,
    SCP_ST_MR_BAD,
    SCP_ST_CAL_SLOW,
    SCP_ST_CAL_ARM
  } scp_state_t;
endpackage

// *** common/scp_ui_if.sv ***
// Carrier between the panel controller, its debouncer and its LED sequencer.
// All signals on the panel clock.
`timescale 1ns/1ps
`default_nettype none
interface scp_ui_if;
  import scp_pkg::*;
  logic       tick;
  logic       press;
  scp_blink_t blink_mode;
  logic [3:0] blink_count;
  logic       blink_led;
  logic       fast_phase;

  modport ctrl (output tick, blink_mode, blink_count, input press, blink_led, fast_phase);
  modport deb  (input tick, output press);
  modport blk  (input tick, blink_mode, blink_count, output blink_led, fast_phase);
endinterface
`default_nettype wire

// *** rtl/scp_debounce.sv ***
// Push-button debouncer: one press pulse per accepted press.
// Expects an already synchronised button level and a 1 ms tick.
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
module scp_debounce (
  input  wire logic clock,   // panel clock
  input  wire logic rst,     // async reset
  input  wire logic button,  // synchronised level, high = pressed
  scp_ui_if.deb     ui       // tick in, press out
);
  import scp_pkg::*;
  logic       stable;
  logic [7:0] same_ms;

  wire changed = (button != stable);
  wire settled = ui.tick && (same_ms >= `SCP_DEBOUNCE_MS - 8'h01);

  // Level must hold the full window; bounces restart it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stable  <= 1'b0;
      same_ms <= 8'h00;
      ui.press <= 1'b0;
    end else begin
      ui.press <= 1'b0;
      if (!changed) begin
        same_ms <= 8'h00;
      end else if (settled) begin
        stable   <= button;
        same_ms  <= 8'h00;
        ui.press <= button;
      end else if (ui.tick) begin
        same_ms <= same_ms + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/scp_blinker.sv ***
// Green LED sequencer: off, slow, fast, or count-flash-pause-repeat.
// Also a free fast phase used for red error flashing. Needs a 1 ms tick.
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
module scp_blinker (
  input  wire logic clock,  // panel clock
  input  wire logic rst,    // async reset
  scp_ui_if.blk     ui      // mode/count in, led out
);
  import scp_pkg::*;
  scp_blink_t  mode_q;
  logic [11:0] ms;
  logic [11:0] fast_ms;
  logic [3:0]  idx;

  wire [11:0] ms_inc   = ms + 12'h001;
  wire        in_gap   = (idx < ui.blink_count);
  wire [11:0] half     = (ui.blink_mode == SCP_BLINK_SLOW) ? `SCP_SLOW_HALF_MS
                                                            : `SCP_FAST_HALF_MS;
  wire [11:0] gap_len  = in_gap ? `SCP_CNT_OFF_MS : `SCP_CNT_PAUSE_MS;
  wire        fast_end = (fast_ms + 12'h001 >= `SCP_FAST_HALF_MS);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fast_ms       <= 12'h000;
      ui.fast_phase <= 1'b0;
    end else if (ui.tick) begin
      fast_ms       <= fast_end ? 12'h000 : fast_ms + 12'h001;
      ui.fast_phase <= fast_end ? !ui.fast_phase : ui.fast_phase;
    end
  end

  // Restart the pattern on any mode change so a count always starts clean
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q       <= SCP_BLINK_OFF;
      ms           <= 12'h000;
      idx          <= 4'h0;
      ui.blink_led <= 1'b0;
    end else if (ui.blink_mode != mode_q) begin
      mode_q       <= ui.blink_mode;
      ms           <= 12'h000;
      idx          <= 4'h0;
      ui.blink_led <= 1'b0;
    end else if (ui.tick) begin
      ms <= ms_inc;
      unique case (mode_q)
        SCP_BLINK_OFF: ui.blink_led <= 1'b0;
        SCP_BLINK_SLOW, SCP_BLINK_FAST: begin
          if (ms_inc >= half) begin
            ms           <= 12'h000;
            ui.blink_led <= !ui.blink_led;
          end
        end
        SCP_BLINK_COUNT: begin
          if (ui.blink_led && ms_inc >= `SCP_CNT_ON_MS) begin
            ms           <= 12'h000;
            ui.blink_led <= 1'b0;
            idx          <= idx + 4'h1;
          end else if (!ui.blink_led && ms_inc >= gap_len) begin
            ms           <= 12'h000;
            ui.blink_led <= in_gap || (ui.blink_count != 4'h0);
            idx          <= in_gap ? idx : 4'h0;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verif/scp_panel_monitor.sv ***
// Port checker for scp_panel.
// Bound to the design from tb_top; one clock, reset active high.
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
module scp_panel_monitor (
  input wire logic        clock,            // panel clock
  input wire logic        rst,              // async reset
  input wire logic        cfg_en_pin,       // set-up switch
  input wire logic [2:0]  sel_pin,          // section select
  input wire logic [3:0]  rotary_pin,       // rotary
  input wire logic        button_pin,       // button
  input wire logic [2:0]  op_mode,          // mode
  input wire logic [23:0] range_period_us,  // range period
  input wire logic        run_led_green,    // run green
  input wire logic        run_led_red,      // run red
  input wire logic        led_green,        // green LED
  input wire logic        led_red,          // red LED
  input wire logic [3:0]  max_resp_setting, // setting
  input wire logic [23:0] max_resp_us,      // response time
  input wire logic [15:0] cal_min,          // minimum
  input wire logic [15:0] cal_fs,           // full scale
  input wire logic        user_cal_valid,   // user cal
  input wire logic        nvm_save          // save pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  localparam logic [23:0] MR_TAB [1:9] = '{`SCP_MR_T1_US, `SCP_MR_T2_US, `SCP_MR_T3_US,
    `SCP_MR_T4_US, `SCP_MR_T5_US, `SCP_MR_T6_US, `SCP_MR_T7_US, `SCP_MR_T8_US, `SCP_MR_T9_US};
  wire logic [33:0] raw = {range_period_us, 10'h000};
  wire logic [23:0] mr0 = (raw < `SCP_MR_MIN_US) ? 24'h009c40 :
                          (raw > `SCP_MR_MAX_US) ? 24'h989680 : raw[23:0];
  sequence s_setting_held;
    $stable(max_resp_setting)[*2];
  endsequence
  sequence s_mode_held;
    $stable(op_mode)[*4];
  endsequence
  a_fixed_time: assert property (s_setting_held ##0 (max_resp_setting inside {[1:9]})
    |-> max_resp_us == MR_TAB[max_resp_setting]) else $error("fixed time wrong");
  a_period_time: assert property (s_setting_held ##0 $stable(range_period_us) ##0
    (max_resp_setting == 4'h0) |-> max_resp_us == mr0) else $error("period time wrong");
  a_setting_valid: assert property (max_resp_setting <= 4'h9)
    else $error("setting out of range");
  a_setting_source: assert property ($changed(max_resp_setting)
    |-> $past(cfg_en_pin, 4) && $past(sel_pin, 4) == `SCP_SEL_MAXRESP)
    else $error("setting changed outside its section");
  a_save_single: assert property (nvm_save |=> !nvm_save)
    else $error("save pulse too long");
  a_valid_by_save: assert property ($rose(user_cal_valid) |-> nvm_save || $past(nvm_save))
    else $error("user cal without save");
  a_min_below_fs: assert property (cal_min <= cal_fs)
    else $error("minimum above full scale");
  a_volt_ceiling: assert property (s_mode_held ##0 (op_mode inside {3'h1, 3'h2})
    |-> cal_fs <= `SCP_ABS_MAX_V) else $error("full scale above limit");
  a_quiet_in_run: assert property (!cfg_en_pin [*5] |-> !nvm_save)
    else $error("save while running");
endmodule
`default_nettype wire

// *** verif/scp_operator.sv ***
// Operator model: rotary switch and push-button with contact bounce.
// Drives on the falling edge; the bench calls press() hierarchically.
`timescale 1ns/1ps
`default_nettype none
module scp_operator #(
  parameter int HOLD = 100  // cycles held pressed and released
) (
  input  wire logic       clock,      // panel clock
  output logic            button_pin, // high while pressed
  output logic [3:0]      rotary_pin  // switch position
);
  initial begin
    button_pin = 1'b0;
    rotary_pin = 4'h0;
  end
  task automatic press(input logic [3:0] pos);
    @(negedge clock);
    rotary_pin = pos;
    // Short bounce first, too brief to count
    button_pin = 1'b1;
    repeat (8) @(negedge clock);
    button_pin = 1'b0;
    repeat (8) @(negedge clock);
    button_pin = 1'b1;
    repeat (HOLD) @(negedge clock);
    button_pin = 1'b0;
    repeat (HOLD) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for scp_panel, 1 ms scaled to 4 clocks.
// Operator model supplies button and rotary; other inputs driven here.
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_en_pin = 1'b0;
  logic [2:0]  sel_pin = 3'h0;
  logic [2:0]  op_mode = `SCP_MODE_V10;
  logic [23:0] range_period_us = 24'h000064;
  logic        run_led_green = 1'b0;
  logic        run_led_red = 1'b1;
  wire logic   button_pin;
  wire logic [3:0] rotary_pin;
  logic        led_green, led_red, user_cal_valid, nvm_save;
  logic [3:0]  max_resp_setting;
  logic [23:0] max_resp_us;
  logic [15:0] cal_min, cal_fs;
  int          miscompares = 0;
  int          total_checks = 0;
  int          saves = 0;
  int          n;
  logic [23:0] mr_tab [1:9] = '{24'h002710, 24'h004e20, 24'h00c350, 24'h0186a0,
    24'h030d40, 24'h07a120, 24'h0f4240, 24'h4c4b40, 24'h989680};
  always #12.5 clock = ~clock;
  always @(posedge clock) if (nvm_save === 1'b1) saves++;
  scp_panel #(.TICK_CYCLES(4)) scp_panel_inst (.clock, .rst, .cfg_en_pin, .sel_pin,
    .rotary_pin, .button_pin, .op_mode, .range_period_us, .run_led_green, .run_led_red,
    .led_green, .led_red, .max_resp_setting, .max_resp_us, .cal_min, .cal_fs,
    .user_cal_valid, .nvm_save);
  scp_operator scp_operator_inst (.clock, .button_pin, .rotary_pin);
  task press(input logic [3:0] pos);
    scp_operator_inst.press(pos);
  endtask
  // Rising edges of one LED over a window; red when which is set
  task rises(input bit which, input int cyc, output int cnt);
    logic prev;
    prev = 1'b1;
    cnt = 0;
    repeat (cyc) begin
      @(negedge clock);
      if ((which ? led_red : led_green) === 1'b1 && !prev) cnt++;
      prev = which ? led_red : led_green;
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1_500_000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (10) @(negedge clock);
    `CHK("setting", 4'h0, max_resp_setting)
    `CHK("mr period", 24'h019000, max_resp_us)
    `CHK("fs factory", 16'h2710, cal_fs)
    range_period_us = 24'h00000a;
    repeat (4) @(negedge clock);
    `CHK("mr floor", 24'h009c40, max_resp_us)
    range_period_us = 24'h002710;
    repeat (4) @(negedge clock);
    `CHK("mr ceiling", 24'h989680, max_resp_us)
    $display("test reset done");
    cfg_en_pin = 1'b1;
    sel_pin = `SCP_SEL_MAXRESP;
    for (int k = 1; k < 10; k++) begin
      press(4'h0);
      press(4'(k));
      `CHK("setting", 4'(k), max_resp_setting)
      `CHK("mr time", mr_tab[k], max_resp_us)
    end
    press(4'h0);
    rises(1'b0, 8000, n);
    `CHK("edit blink", 10, n)
    press(4'hc);
    `CHK("bad kept", 4'h9, max_resp_setting)
    rises(1'b1, 1601, n);
    `CHK("bad red", 2, n)
    press(4'h3);
    `CHK("good after bad", 4'h3, max_resp_setting)
    rises(1'b0, 10000, n);
    `CHK("count flashes", 3, n)
    $display("test max response done");
    sel_pin = `SCP_SEL_CAL_MIN;
    repeat (10) @(negedge clock);
    `CHK("dir up", 1'b0, led_red)
    rises(1'b0, 8000, n);
    `CHK("slow blink", 2, n)
    press(4'h0);
    rises(1'b0, 8000, n);
    `CHK("fast blink", 10, n)
    press(4'h8);
    `CHK("step 8", 16'h0190, cal_min)
    press(4'h8);
    `CHK("accumulate", 16'h0320, cal_min)
    press(4'h9);
    `CHK("dir down", 1'b1, led_red)
    press(4'h1);
    `CHK("step 1 down", 16'h031d, cal_min)
    press(4'h0);
    `CHK("saved", 1, saves)
    `CHK("user valid", 1'b1, user_cal_valid)
    press(4'h8);
    press(4'h8);
    `CHK("clamp min", 16'h0000, cal_min)
    rises(1'b1, 1601, n);
    `CHK("clamp red", 1'b1, n > 0)
    cfg_en_pin = 1'b0;
    repeat (10) @(negedge clock);
    `CHK("revert stored", 16'h031d, cal_min)
    cfg_en_pin = 1'b1;
    repeat (10) @(negedge clock);
    `CHK("dir reset", 1'b0, led_red)
    press(4'h0);
    press(4'h0);
    press(4'h0);
    `CHK("factory min", 16'h0000, cal_min)
    `CHK("user cleared", 1'b0, user_cal_valid)
    `CHK("reload pulse", 2, saves)
    $display("test minimum done");
    sel_pin = `SCP_SEL_CAL_FS;
    repeat (10) @(negedge clock);
    press(4'h0);
    for (int k = 0; k < 3; k++) press(4'h8);
    `CHK("fs limit", 16'h2af8, cal_fs)
    press(4'h0);
    `CHK("fs saved", 1'b1, user_cal_valid)
    cfg_en_pin = 1'b0;
    op_mode = `SCP_MODE_V5;
    repeat (10) @(negedge clock);
    `CHK("other mode fs", 16'h1388, cal_fs)
    `CHK("other mode user", 1'b0, user_cal_valid)
    $display("test full scale done");
    end_of_test();
  end
endmodule
bind scp_panel scp_panel_monitor scp_panel_monitor_inst (.clock, .rst, .cfg_en_pin, .sel_pin,
  .rotary_pin, .button_pin, .op_mode, .range_period_us, .run_led_green, .run_led_red,
  .led_green, .led_red, .max_resp_setting, .max_resp_us, .cal_min, .cal_fs,
  .user_cal_valid, .nvm_save);
`default_nettype wire
